// ===== verilog/modbus_slave_end.sv
// driver end: query decode, register file, indirect reference, home request
// assumes a half-duplex master that waits for each answer before the next query
//
// Functional notes
// R1 - home request is bit 4 of 007Dh
// R2 - writing 0010h there starts high-speed homing
// R3 - master sets flag with function 06h
// R4 - master writes 0000h after homing ends
// R5 - frames end in CRC-16, low byte first
// R6 - direct data write starts motion same transaction
// R7 - one query reaches consecutive registers
// R8 - master splits non-consecutive direct accesses
// R9 - stored data waits for remote start input
// R10 - thirty-two pointer slots and value areas
// R11 - pointer slot holds item identifier
// R12 - register address is twice the identifier
// R13 - value area carries the pointed item
// R14 - one query reaches scattered items via areas
// R15 - multi-write 10h with count and byte count
// R16 - pointer slots accept 0 to 65535
// R17 - single write answered by echo
// R18 - area n routes through pointer slot n
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
module modbus_slave_end
  import modbus_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  modbus_link_if.device link,
  output logic home_return_request,
  output logic home_start,
  output logic op_start,
  output logic [31:0] op_data,
  output logic frame_error
);
  logic [7:0] rx_buf [`BUF_BYTES];
  logic [7:0] tx_buf [`BUF_BYTES];
  logic [15:0] item_mem [`ITEM_WORDS];
  logic [15:0] ptr_mem [`SLOTS];
  dev_state_t state_reg;
  logic [5:0] rx_cnt_reg;
  logic [15:0] rx_crc_reg;
  logic rx_over_reg;
  logic [7:0] fc_reg;
  logic [15:0] start_reg;
  logic [4:0] count_reg;
  logic [4:0] idx_reg;
  logic [5:0] tx_len_reg;
  logic [5:0] tx_cnt_reg;
  logic [15:0] tx_crc_reg;
  logic trig_reg;
  logic home_prev_reg;
  logic start_prev_reg;

  // ***************************************************************
  // address map helpers
  // ***************************************************************
  function automatic region_t region(input logic [15:0] a);
    if (a < `ITEM_WORDS) return RG_ITEM;
    if (a >= `PTR_BASE && a < `AREA_BASE) return RG_PTR;
    if (a >= `AREA_BASE && a < `AREA_END) return RG_AREA;
    return RG_NONE;
  endfunction

  // an area resolves to twice the id in its own slot, plus its half
  function automatic logic [15:0] eff_addr(input logic [15:0] a);
    logic [15:0] id;
    id = ptr_mem[a[5:1]];
    if (region(a) != RG_AREA) return a;
    if (id[15]) return 16'hFFFF; // beyond any register address
    return {id[14:0], a[0]}; // R12 R18
  endfunction

  function automatic logic [15:0] rd_word(input logic [15:0] a);
    logic [15:0] e;
    e = eff_addr(a);
    unique case (region(a))
      RG_ITEM: return item_mem[a[6:0]];
      RG_PTR: return a[0] ? ptr_mem[a[5:1]] : 16'h0000;
      RG_AREA: return (region(e) == RG_ITEM) ? item_mem[e[6:0]] : 16'h0000; // R13
      RG_NONE: return 16'h0000;
    endcase
  endfunction

  // ***************************************************************
  // query decode
  // ***************************************************************
  logic [7:0] q_fc;
  logic [15:0] q_start;
  logic [15:0] q_cnt;
  logic [15:0] q_end;
  logic [7:0] q_exc;
  logic [15:0] cur_a;
  logic [15:0] wr_val;
  logic [15:0] wr_eff;
  logic wr_en;
  logic [5:0] widx;
  logic [15:0] rd_val;

  // check codes in the order a master expects: function, value, address
  always_comb begin
    q_fc = rx_buf[1];
    q_start = {rx_buf[2], rx_buf[3]};
    q_cnt = (q_fc == `FC_WRITE1) ? 16'h0001 : {rx_buf[4], rx_buf[5]};
    q_end = 16'(q_start + q_cnt - 16'h0001);
    q_exc = 8'h00;
    if (q_fc != `FC_READ && q_fc != `FC_WRITE1 && q_fc != `FC_WRITEN) begin
      q_exc = `EXC_FUNC;
    end else if (q_cnt == 16'h0000 || q_cnt > `MAX_REGS) begin
      q_exc = `EXC_VALUE;
    end else if (q_fc == `FC_WRITEN && ({8'h00, rx_buf[6]} != 16'(q_cnt << 1) ||
                 {10'h000, rx_cnt_reg} != 16'(`WN_OVERHEAD + (q_cnt << 1)))) begin
      q_exc = `EXC_VALUE; // R15
    end else if (q_fc != `FC_WRITEN && rx_cnt_reg != `SHORT_FRAME) begin
      q_exc = `EXC_VALUE;
    end else if (region(q_start) == RG_NONE || region(q_start) != region(q_end)) begin
      q_exc = `EXC_ADDR; // R7
    end
  end

  // one register per cycle during execution
  always_comb begin
    cur_a = 16'(start_reg + {11'h000, idx_reg});
    widx = 6'(`WN_HDR_BYTES + {idx_reg, 1'b0});
    wr_val = (fc_reg == `FC_WRITE1) ? {rx_buf[4], rx_buf[5]} :
             {rx_buf[widx], rx_buf[6'(widx + 6'd1)]};
    wr_eff = eff_addr(cur_a);
    rd_val = rd_word(cur_a);
    wr_en = (state_reg == D_EXEC) && (fc_reg != `FC_READ);
  end

  // ***************************************************************
  // receive path
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt_reg <= 6'd0;
      rx_crc_reg <= `CRC_INIT;
      rx_over_reg <= 1'b0;
    end else if (state_reg == D_CHECK) begin
      rx_cnt_reg <= 6'd0;
      rx_crc_reg <= `CRC_INIT;
      rx_over_reg <= 1'b0;
    end else if (state_reg == D_IDLE && link.q_valid) begin
      rx_crc_reg <= crc16_byte(rx_crc_reg, link.q_data); // R5
      if (rx_cnt_reg == 6'(`BUF_BYTES - 1)) begin
        rx_over_reg <= 1'b1;
      end else begin
        rx_cnt_reg <= 6'(rx_cnt_reg + 6'd1);
      end
    end
  end

  // bytes past the buffer are dropped; the frame is then discarded
  always_ff @(posedge hclk) begin
    if (state_reg == D_IDLE && link.q_valid && !rx_over_reg) begin
      rx_buf[rx_cnt_reg] <= link.q_data;
    end
  end

  // ***************************************************************
  // control sequence
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= D_IDLE;
      fc_reg <= 8'h00;
      start_reg <= 16'h0000;
      count_reg <= 5'd0;
      idx_reg <= 5'd0;
      tx_len_reg <= 6'd0;
    end else begin
      unique case (state_reg)
        D_IDLE: begin
          if (link.q_valid && link.q_last) state_reg <= D_CHECK;
        end
        D_CHECK: begin
          fc_reg <= q_fc;
          start_reg <= q_start;
          count_reg <= q_cnt[4:0];
          idx_reg <= 5'd0;
          // frames for another address or with a bad check get no answer
          if (rx_crc_reg != 16'h0000 || rx_over_reg || rx_buf[0] != `SLAVE_ID ||
              rx_cnt_reg < `FRAME_MIN) begin
            state_reg <= D_IDLE;
          end else if (q_exc != 8'h00) begin
            tx_len_reg <= 6'(`RD_HDR_BYTES);
            state_reg <= D_RESP;
          end else begin
            tx_len_reg <= (q_fc == `FC_READ) ? 6'(`RD_HDR_BYTES + {q_cnt[4:0], 1'b0}) :
                          6'(`HDR_BYTES); // R17
            state_reg <= D_EXEC;
          end
        end
        D_EXEC: begin
          idx_reg <= 5'(idx_reg + 5'd1);
          if (idx_reg == 5'(count_reg - 5'd1)) state_reg <= D_RESP;
        end
        D_RESP: begin
          if (tx_cnt_reg == 6'(tx_len_reg + 6'd1)) state_reg <= D_IDLE;
        end
        default: state_reg <= D_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // register file: items (direct space) and pointer slots
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `ITEM_WORDS; i++) item_mem[i] <= 16'h0000;
    end else if (wr_en && region(wr_eff) == RG_ITEM) begin
      item_mem[wr_eff[6:0]] <= wr_val; // R7 R13 R14
    end
  end

  // full 16-bit ids are kept; only ids below 0040h, half the item space, resolve
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `SLOTS; i++) ptr_mem[i] <= 16'h0000; // R10
    end else if (wr_en && region(cur_a) == RG_PTR && cur_a[0]) begin
      ptr_mem[cur_a[5:1]] <= wr_val; // R11 R16
    end
  end

  // ***************************************************************
  // response builder and transmitter
  // ***************************************************************
  always_ff @(posedge hclk) begin
    if (state_reg == D_CHECK) begin
      tx_buf[0] <= rx_buf[0];
      tx_buf[1] <= (q_exc != 8'h00) ? (q_fc | `FC_EXC_BIT) : q_fc;
      tx_buf[2] <= (q_exc != 8'h00) ? q_exc : (q_fc == `FC_READ) ? 8'(q_cnt << 1) : rx_buf[2];
      tx_buf[3] <= rx_buf[3]; // R17
      tx_buf[4] <= rx_buf[4];
      tx_buf[5] <= rx_buf[5];
    end else if (state_reg == D_EXEC && fc_reg == `FC_READ) begin
      tx_buf[6'(`RD_HDR_BYTES + {idx_reg, 1'b0})] <= rd_val[15:8];
      tx_buf[6'(`RD_HDR_BYTES + {idx_reg, 1'b0} + 1)] <= rd_val[7:0];
    end
  end

  // check trails the frame, low byte then high byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt_reg <= 6'd0;
      tx_crc_reg <= `CRC_INIT;
      link.r_valid <= 1'b0;
      link.r_data <= 8'h00;
      link.r_last <= 1'b0;
    end else if (state_reg == D_RESP) begin
      tx_cnt_reg <= 6'(tx_cnt_reg + 6'd1);
      link.r_valid <= 1'b1;
      link.r_last <= (tx_cnt_reg == 6'(tx_len_reg + 6'd1));
      if (tx_cnt_reg < tx_len_reg) begin
        link.r_data <= tx_buf[tx_cnt_reg];
        tx_crc_reg <= crc16_byte(tx_crc_reg, tx_buf[tx_cnt_reg]);
      end else begin
        link.r_data <= (tx_cnt_reg == tx_len_reg) ? tx_crc_reg[7:0] : tx_crc_reg[15:8]; // R5
      end
    end else begin
      tx_cnt_reg <= 6'd0;
      tx_crc_reg <= `CRC_INIT;
      link.r_valid <= 1'b0;
      link.r_last <= 1'b0;
    end
  end

  // ***************************************************************
  // motion requests
  // ***************************************************************
  // a direct data write arms a start that fires as the query completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_reg <= 1'b0;
    end else if (state_reg == D_CHECK) begin
      trig_reg <= 1'b0;
    end else if (wr_en && (wr_eff & 16'hFFFE) == `REG_DIRECT_TRIG) begin
      trig_reg <= 1'b1; // R6
    end
  end

  // flags follow the command word; starts are single-cycle edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      home_prev_reg <= 1'b0;
      start_prev_reg <= 1'b0;
      home_return_request <= 1'b0;
      home_start <= 1'b0;
      op_start <= 1'b0;
      op_data <= 32'h0000_0000;
      frame_error <= 1'b0;
    end else begin
      home_prev_reg <= item_mem[`REG_DRV_CMD][`HOME_BIT];
      start_prev_reg <= item_mem[`REG_DRV_CMD][`START_BIT];
      home_return_request <= item_mem[`REG_DRV_CMD][`HOME_BIT]; // R1
      home_start <= item_mem[`REG_DRV_CMD][`HOME_BIT] && !home_prev_reg; // R2
      op_start <= (item_mem[`REG_DRV_CMD][`START_BIT] && !start_prev_reg) || // R9
                  (state_reg == D_EXEC && idx_reg == 5'(count_reg - 5'd1) &&
                   (trig_reg || (wr_en && (wr_eff & 16'hFFFE) == `REG_DIRECT_TRIG))); // R6
      op_data <= {item_mem[`REG_OPDATA_HI], item_mem[`REG_OPDATA_LO]};
      frame_error <= (state_reg == D_CHECK) && (rx_crc_reg != 16'h0000 || rx_over_reg);
    end
  end
endmodule

// ===== verilog/modbus_params.svh
// named constants shared by both ends of the register-command link
// assumes a 125 MHz hclk and one byte per clock on the link
`ifndef MODBUS_PARAMS_SVH
`define MODBUS_PARAMS_SVH

`define SLAVE_ID 8'h01
`define FC_READ 8'h03
`define FC_WRITE1 8'h06
`define FC_WRITEN 8'h10
`define FC_EXC_BIT 8'h80
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define REG_DRV_CMD 7'h7D
`define HOME_BIT 4
`define START_BIT 3
`define REG_DIRECT_TRIG 16'h0042
`define REG_OPDATA_HI 7'h40
`define REG_OPDATA_LO 7'h41
`define ITEM_WORDS 16'h0080
`define PTR_BASE 16'h1300
`define AREA_BASE 16'h1340
`define AREA_END 16'h1380
`define SLOTS 32
`define MAX_REGS 16
`define BUF_BYTES 48
`define HDR_BYTES 6
`define WN_HDR_BYTES 7
`define RD_HDR_BYTES 3
`define FRAME_MIN 4
`define WN_OVERHEAD 9
`define SHORT_FRAME 8
// host register offsets (byte addresses, one word each)
`define H_CMD 8'h00
`define H_START 8'h04
`define H_COUNT 8'h08
`define H_STATUS 8'h0C
`define H_SLAVE 8'h10
`define H_DATA 8'h40
`define H_DATA_END 8'h80
`define ST_BUSY 0
`define ST_DONE 1
`define ST_CRC 2
`define ST_EXC 3

`endif

// ===== verilog/modbus_pkg.sv
// types and the frame check shared by both ends
// assumes modbus_params.svh is on the include path
package modbus_pkg;
  `include "modbus_params.svh"

  typedef enum logic [2:0] {D_IDLE, D_CHECK, D_EXEC, D_RESP} dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} host_state_t;
  typedef enum logic [1:0] {RG_NONE, RG_ITEM, RG_PTR, RG_AREA} region_t;

  // one byte of the frame check, reflected polynomial, low byte goes first
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// ===== verilog/modbus_link_if.sv
// byte-wide query and response lanes between master and driver
// assumes both ends run on the same hclk; one byte per valid pulse
`timescale 1ns/10ps
interface modbus_link_if;
  logic q_valid;
  logic [7:0] q_data;
  logic q_last;
  logic r_valid;
  logic [7:0] r_data;
  logic r_last;

  modport device (input q_valid, input q_data, input q_last,
                  output r_valid, output r_data, output r_last);
  modport host (output q_valid, output q_data, output q_last,
                input r_valid, input r_data, input r_last);
endinterface

// ===== verilog/modbus_master_end.sv
// master end: AHB-Lite register slave that builds queries and parses answers
// assumes software writes one query at a time and polls the busy bit
`timescale 1ns/10ps
module modbus_master_end
  import modbus_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  modbus_link_if.host link
);
  logic [15:0] data_mem [`MAX_REGS];
  host_state_t state_reg;
  logic [7:0] slave_reg;
  logic [7:0] fc_reg;
  logic [15:0] start_reg;
  logic [4:0] count_reg;
  logic busy_reg, done_reg, crc_err_reg, exc_reg;
  logic [7:0] exc_code_reg;
  logic ap_wr_reg, ap_rd_reg;
  logic [7:0] ap_addr_reg;
  logic [5:0] k_reg;
  logic [15:0] crc_reg;
  logic [7:0] tx_byte;
  logic [5:0] tx_len;
  logic [15:0] rx_crc;
  logic [5:0] rk_data;
  logic go;

  // ***************************************************************
  // AHB-Lite slave: writes zero-wait, reads one wait state
  // ***************************************************************
  // the wait state lets a read see a write finished in the cycle before
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'b0;
      ap_rd_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      if (ap_rd_reg) begin
        hreadyout <= 1'b1;
        ap_rd_reg <= 1'b0;
        if (ap_addr_reg == `H_STATUS) begin
          hrdata <= {8'h00, slave_reg, exc_code_reg,
                     4'h0, exc_reg, crc_err_reg, done_reg, busy_reg};
        end else if (ap_addr_reg == `H_CMD) begin
          hrdata <= {24'h00_0000, fc_reg};
        end else if (ap_addr_reg == `H_START) begin
          hrdata <= {16'h0000, start_reg};
        end else if (ap_addr_reg == `H_COUNT) begin
          hrdata <= {27'h000_0000, count_reg};
        end else if (ap_addr_reg == `H_SLAVE) begin
          hrdata <= {24'h00_0000, slave_reg};
        end else if (ap_addr_reg >= `H_DATA && ap_addr_reg < `H_DATA_END) begin
          hrdata <= {16'h0000, data_mem[ap_addr_reg[5:2]]};
        end else begin
          hrdata <= 32'h0000_0000; // unmapped reads as zero
        end
      end else if (hsel && htrans[1] && hready) begin
        ap_addr_reg <= haddr[7:0];
        ap_wr_reg <= hwrite;
        ap_rd_reg <= !hwrite;
        hreadyout <= hwrite;
      end else begin
        ap_wr_reg <= 1'b0;
      end
    end
  end

  assign go = ap_wr_reg && ap_addr_reg == `H_CMD && !busy_reg;

  // configuration words; writes while busy to cmd, start, count or slave are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slave_reg <= `SLAVE_ID;
      fc_reg <= `FC_READ;
      start_reg <= 16'h0000;
      count_reg <= 5'd1;
    end else if (ap_wr_reg && !busy_reg) begin
      if (ap_addr_reg == `H_CMD) fc_reg <= hwdata[7:0];
      if (ap_addr_reg == `H_START) start_reg <= hwdata[15:0];
      if (ap_addr_reg == `H_COUNT) count_reg <= hwdata[4:0];
      if (ap_addr_reg == `H_SLAVE) slave_reg <= hwdata[7:0];
    end
  end

  // ***************************************************************
  // query builder
  // ***************************************************************
  always_comb begin
    tx_len = (fc_reg == `FC_WRITEN) ? 6'(`WN_HDR_BYTES + {count_reg, 1'b0}) :
             6'(`HDR_BYTES);
    tx_byte = 8'h00;
    unique case (k_reg)
      6'd0: tx_byte = slave_reg;
      6'd1: tx_byte = fc_reg;
      6'd2: tx_byte = start_reg[15:8];
      6'd3: tx_byte = start_reg[7:0];
      6'd4: tx_byte = (fc_reg == `FC_WRITE1) ? data_mem[0][15:8] : 8'h00; // R3
      6'd5: tx_byte = (fc_reg == `FC_WRITE1) ? data_mem[0][7:0] : {3'b000, count_reg};
      6'd6: tx_byte = {2'b00, count_reg, 1'b0}; // R15
      default: tx_byte = k_reg[0] ? data_mem[4'(6'(k_reg - 6'd7) >> 1)][15:8] :
                         data_mem[4'(6'(k_reg - 6'd7) >> 1)][7:0];
    endcase
    rx_crc = crc16_byte(crc_reg, link.r_data);
    rk_data = 6'(k_reg - 6'(`RD_HDR_BYTES));
  end

  // ***************************************************************
  // transfer sequence and status
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= H_IDLE;
      k_reg <= 6'd0;
      crc_reg <= `CRC_INIT;
      link.q_valid <= 1'b0;
      link.q_data <= 8'h00;
      link.q_last <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      link.q_valid <= 1'b0;
      link.q_last <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          k_reg <= 6'd0;
          crc_reg <= `CRC_INIT;
          if (go) begin
            busy_reg <= 1'b1;
            state_reg <= H_SEND;
          end
        end
        H_SEND: begin
          k_reg <= 6'(k_reg + 6'd1);
          link.q_valid <= 1'b1;
          if (k_reg < tx_len) begin
            link.q_data <= tx_byte;
            crc_reg <= crc16_byte(crc_reg, tx_byte);
          end else if (k_reg == tx_len) begin
            link.q_data <= crc_reg[7:0]; // R5
          end else begin
            link.q_data <= crc_reg[15:8];
            link.q_last <= 1'b1;
            k_reg <= 6'd0;
            crc_reg <= `CRC_INIT;
            state_reg <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.r_valid) begin
            k_reg <= 6'(k_reg + 6'd1);
            crc_reg <= rx_crc;
            if (link.r_last) begin
              busy_reg <= 1'b0;
              state_reg <= H_IDLE;
            end
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_reg <= 1'b0;
      crc_err_reg <= 1'b0;
      exc_reg <= 1'b0;
      exc_code_reg <= 8'h00;
    end else begin
      if (ap_wr_reg && ap_addr_reg == `H_STATUS) begin
        if (hwdata[`ST_DONE]) done_reg <= 1'b0;
        if (hwdata[`ST_CRC]) crc_err_reg <= 1'b0;
        if (hwdata[`ST_EXC]) exc_reg <= 1'b0;
      end
      if (state_reg == H_WAIT && link.r_valid) begin
        if (k_reg == 6'd1 && link.r_data[7]) exc_reg <= 1'b1;
        if (k_reg == 6'd2) exc_code_reg <= link.r_data;
        if (link.r_last) begin
          done_reg <= 1'b1;
          if (rx_crc != 16'h0000) crc_err_reg <= 1'b1; // R5
        end
      end
    end
  end

  // data words: software writes when idle, read answers fill them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `MAX_REGS; i++) data_mem[i] <= 16'h0000;
    end else if (ap_wr_reg && !busy_reg && ap_addr_reg >= `H_DATA &&
                 ap_addr_reg < `H_DATA_END) begin
      data_mem[ap_addr_reg[5:2]] <= hwdata[15:0];
    end else if (state_reg == H_WAIT && link.r_valid && fc_reg == `FC_READ &&
                 k_reg >= 6'(`RD_HDR_BYTES) && rk_data < {count_reg, 1'b0}) begin
      if (!rk_data[0]) data_mem[rk_data[4:1]][15:8] <= link.r_data;
      else data_mem[rk_data[4:1]][7:0] <= link.r_data;
    end
  end
endmodule

// ===== test/modbus_link_monitor.sv
// link checker: framing, frame check residue and answer timing
// assumes both ends on hclk; inputs are the link interface signals
`timescale 1ns/10ps
module modbus_link_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic q_valid,
  input wire logic [7:0] q_data,
  input wire logic q_last,
  input wire logic r_valid,
  input wire logic [7:0] r_data,
  input wire logic r_last
);
  logic [15:0] qc_reg;
  logic [15:0] rc_reg;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // own copy of the check step, so a fault in the shared one is not hidden
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  // running checks, restarted after each last byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qc_reg <= 16'hffff;
    end else if (q_valid) begin
      qc_reg <= q_last ? 16'hffff : step(qc_reg, q_data);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_reg <= 16'hffff;
    end else if (r_valid) begin
      rc_reg <= r_last ? 16'hffff : step(rc_reg, r_data);
    end
  end
  // ****
  // properties
  // ****
  sequence s_q_run; q_valid [*4]; endsequence
  sequence s_r_run; r_valid [*5]; endsequence
  property p_q_crc; q_last |-> step(qc_reg, q_data) == 16'h0000; endproperty
  a_q_crc: assert property (p_q_crc) else $error("query check bad");
  property p_r_crc; r_last |-> step(rc_reg, r_data) == 16'h0000; endproperty
  a_r_crc: assert property (p_r_crc) else $error("answer check bad");
  property p_q_run; $rose(q_valid) |-> s_q_run; endproperty
  a_q_run: assert property (p_q_run) else $error("query too short");
  property p_r_run; $rose(r_valid) |-> s_r_run; endproperty
  a_r_run: assert property (p_r_run) else $error("answer too short");
  property p_r_end; r_last |-> r_valid ##1 !r_valid; endproperty
  a_r_end: assert property (p_r_end) else $error("answer end wrong");
  property p_gap; q_last |=> !r_valid && !q_valid; endproperty
  a_gap: assert property (p_gap) else $error("answer too early");
  property p_answer; q_last |-> ##[2:40] r_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_half; r_valid |-> !q_valid; endproperty
  a_half: assert property (p_half) else $error("query during answer");
endmodule

// ===== test/tb_modbus_indirect_reference_homing.sv
// bench: software drives queries through the host end, driver end answers
// assumes the package, header, interface and both ends compiled first
`timescale 1ns/10ps
module tb_modbus_indirect_reference_homing;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic home_return_request, home_start, op_start, frame_error;
  logic [31:0] op_data;
  int n_errors, num_checks, n_home, n_op, cycles, n_ferr;
  modbus_link_if link ();
  modbus_master_end i_modbus_master_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
  modbus_slave_end i_modbus_slave_end (.hclk(hclk), .hresetn(hresetn), .link(link),
    .home_return_request(home_return_request), .home_start(home_start),
    .op_start(op_start), .op_data(op_data), .frame_error(frame_error));
  modbus_link_monitor i_modbus_link_monitor (.hclk(hclk), .hresetn(hresetn),
    .q_valid(link.q_valid), .q_data(link.q_data), .q_last(link.q_last),
    .r_valid(link.r_valid), .r_data(link.r_data), .r_last(link.r_last));
  // ****
  // tasks
  // ****
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer; entered just after an edge, waits on hready only
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // start a query and poll busy; the answer must carry no error flags
  task automatic query(input logic [7:0] fc, input logic [15:0] a, input logic [4:0] n);
    ahb(1'b1, 8'h04, {16'h0000, a});
    ahb(1'b1, 8'h08, {27'h000_0000, n});
    ahb(1'b1, 8'h00, {24'h00_0000, fc});
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0) ahb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd & 32'h0000_000e, 32'h0000_0002);
  endtask
  task automatic chk4();
    logic [31:0] exp [4];
    exp = '{32'h0000_0000, 32'h0000_0000, 32'h0000_1234, 32'h0000_5678};
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, 8'h40 + 8'(4 * i), 32'h0000_0000);
      chk(rd, exp[i]);
    end
  endtask
  // ****
  // clock, pulse counters, hang limit
  // ****
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    n_home += (home_start === 1'b1);
    n_op += (op_start === 1'b1);
    n_ferr += (frame_error | hresp) !== 1'b0;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} <= '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    hsize <= 3'b010;
    @(posedge hclk);
    ahb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // home request set, then dropped after homing
    ahb(1'b1, 8'h40, 32'h0000_0010);
    query(8'h06, 16'h007d, 5'd1);
    chk(home_return_request, 32'h0000_0001);
    chk(n_home, 32'h0000_0001);
    ahb(1'b1, 8'h40, 32'h0000_0000);
    query(8'h06, 16'h007d, 5'd1);
    chk(home_return_request, 32'h0000_0000);
    $display("home test done");
    // pointer slots: extremes of range, readback, then area routing
    ahb(1'b1, 8'h40, 32'h0000_ffff);
    query(8'h06, 16'h1301, 5'd1);
    ahb(1'b1, 8'h40, 32'h0000_0020);
    query(8'h06, 16'h133f, 5'd1);
    query(8'h03, 16'h1301, 5'd1);
    ahb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_ffff);
    query(8'h03, 16'h133f, 5'd1);
    ahb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0020);
    ahb(1'b1, 8'h40, 32'h0000_1234);
    ahb(1'b1, 8'h44, 32'h0000_5678);
    query(8'h10, 16'h137e, 5'd2);
    chk(op_data, 32'h1234_5678);
    chk(n_op, 32'h0000_0000);
    query(8'h03, 16'h137c, 5'd4);
    chk4();
    query(8'h03, 16'h003e, 5'd4);
    chk4();
    $display("indirect test done");
    // remote start, then direct data start
    ahb(1'b1, 8'h40, 32'h0000_0008);
    query(8'h06, 16'h007d, 5'd1);
    chk(n_op, 32'h0000_0001);
    ahb(1'b1, 8'h40, 32'h0000_0001);
    query(8'h06, 16'h0042, 5'd1);
    chk(n_op, 32'h0000_0002);
    chk(n_ferr, 32'h0000_0000);
    $display("start test done");
    complete_run();
  end
endmodule
